//--- core/cfg_regs_pkg.sv
`default_nettype none
package cfg_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] PAGE_MEDIA = 2'h0;
  localparam logic [1:0] PAGE_BOOT = 2'h2;
  localparam logic [3:0] OFFSET_CFG = 4'h0b;

  // ----------------------------------------------------------------
  // Media/status register fields
  // ----------------------------------------------------------------
  localparam int MEDIA_SEL_LSB = 0;
  localparam int LINK_GOOD_BIT = 2;
  localparam int READY_TIMING_BIT = 4;
  localparam int BUS_FAULT_BIT = 5;
  localparam logic [7:0] MEDIA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Boot ROM / plug-and-play register fields
  // ----------------------------------------------------------------
  localparam int BOOT_SEL_LSB = 0;
  localparam int PNP_BIT = 6;
  localparam logic [3:0] BOOT_SEL_RESET = 4'h0;
  localparam logic [5:0] ROM_BASE_16K = 6'h30;
  localparam logic [7:0] RBC_HIGH_RESET = 8'h00;

  typedef enum logic [1:0] {
    MEDIA_TWISTED,
    MEDIA_COAX,
    MEDIA_AUI,
    MEDIA_AUTO
  } media_t;

  typedef enum logic [1:0] {
    ROM_NONE,
    ROM_16K,
    ROM_32K,
    ROM_64K
  } rom_size_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] page;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } host_rsp_t;

endpackage : cfg_regs_pkg
`default_nettype wire

//--- core/rom_window_decode.sv
`default_nettype none
module rom_window_decode
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Select code
  input wire logic [3:0] boot_sel,
  // Decoded window, address bits 19:14
  output logic rom_enable,
  output logic [5:0] rom_base,
  output rom_size_t rom_size
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [5:0] base_of(input logic [3:0] code);
    if (code < 4'ha) begin
      base_of = ROM_BASE_16K + {2'h0, code} - 6'h02;
    end else if (code < 4'he) begin
      base_of = ROM_BASE_16K + {1'b0, code, 1'b0} - 6'h14;
    end else begin
      base_of = code[0] ? ROM_BASE_16K + 6'h04 : ROM_BASE_16K;
    end
  endfunction : base_of

  wire logic enable_next = (boot_sel[3:1] != 3'h0);
  wire rom_size_t size_next = !enable_next ? ROM_NONE :
                              (boot_sel < 4'ha) ? ROM_16K :
                              (boot_sel < 4'he) ? ROM_32K : ROM_64K;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rom_enable <= 1'b0;
      rom_base <= 6'h00;
      rom_size <= ROM_NONE;
    end else if (clk_en) begin
      rom_enable <= enable_next;
      rom_base <= enable_next ? base_of(boot_sel) : 6'h00;
      rom_size <= size_next;
    end
  end

  property p_rom_off;
    @(posedge clk) disable iff (!reset_n)
    clk_en && boot_sel[3:1] == 3'h0 |=> !rom_enable;
  endproperty
  a_rom_off: assert property (p_rom_off)
    else $error("Boot window enabled for a disable code");

endmodule : rom_window_decode
`default_nettype wire

//--- core/media_boot_cfg.sv
`default_nettype none
module media_boot_cfg
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Host register access
  input wire host_req_t host_req,
  output host_rsp_t host_rsp,
  output logic [7:0] remote_byte_count_high,
  // ISA cycle timing
  input wire logic cmd_strobe,
  input wire logic addr_latch_en,
  input wire logic wait_needed,
  output logic ready_low,
  // Media
  input wire logic link_good_flag,
  input wire logic coax_detect,
  output logic coax_enable_out,
  output media_t active_media,
  // Configuration load
  input wire logic cfg_load,
  input wire logic [3:0] load_boot_sel,
  input wire logic plug_play_state,
  // Boot ROM window
  output logic [3:0] boot_sel,
  output logic rom_enable,
  output logic [5:0] rom_base,
  output rom_size_t rom_size
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic unlock_reg;
  logic [1:0] media_sel_reg;
  logic ready_timing_reg;
  logic bus_fault_reg;
  logic link_reg;
  logic pnp_reg;
  logic cmd_prev_reg;
  logic ale_prev_reg;

  wire logic hit_media = host_req.page == PAGE_MEDIA && host_req.addr == OFFSET_CFG;
  wire logic hit_boot = host_req.page == PAGE_BOOT && host_req.addr == OFFSET_CFG;
  wire logic media_wr = host_req.wr && hit_media && unlock_reg;
  wire logic rbc_wr = host_req.wr && hit_media && !unlock_reg;
  wire logic boot_wr = host_req.wr && hit_boot && !cfg_load;
  wire logic unlock_next = host_req.rd ? hit_media : (host_req.wr ? 1'b0 : unlock_reg);

  wire logic [7:0] media_view = {2'b00, bus_fault_reg, ready_timing_reg, 1'b0,
                                 link_reg, media_sel_reg};
  wire logic [7:0] boot_view = {1'b0, pnp_reg, 2'b00, boot_sel};
  wire logic [7:0] rdata_next = hit_media ? media_view :
                                hit_boot ? boot_view : 8'h00;

  // ----------------------------------------------------------------
  // Wait-state control
  // ----------------------------------------------------------------
  wire logic cmd_rise = cmd_strobe && !cmd_prev_reg;
  wire logic cmd_fall = !cmd_strobe && cmd_prev_reg;
  wire logic ale_rise = addr_latch_en && !ale_prev_reg;
  wire logic start_wait = wait_needed && (ready_timing_reg ? ale_rise : cmd_rise);
  wire logic ready_next = ready_low ? (wait_needed && !cmd_fall) : start_wait;
  // Host dropped the strobe while ready was still held low
  wire logic fault_set = ready_low && cmd_fall && wait_needed;
  wire logic fault_clr = media_wr && !host_req.wdata[BUS_FAULT_BIT];

  // ----------------------------------------------------------------
  // Media selection
  // ----------------------------------------------------------------
  wire media_t fixed_media = media_t'(media_sel_reg);
  wire media_t sensed_media = link_reg ? MEDIA_TWISTED :
                              (coax_detect ? MEDIA_COAX : MEDIA_AUI);
  wire media_t media_next = (fixed_media == MEDIA_AUTO) ? sensed_media : fixed_media;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_reg <= 1'b0;
      media_sel_reg <= MEDIA_RESET[1:0];
      ready_timing_reg <= 1'b0;
      remote_byte_count_high <= RBC_HIGH_RESET;
    end else if (clk_en) begin
      unlock_reg <= unlock_next;
      if (media_wr) begin
        media_sel_reg <= host_req.wdata[MEDIA_SEL_LSB +: 2];
        ready_timing_reg <= host_req.wdata[READY_TIMING_BIT];
      end
      if (rbc_wr) begin
        remote_byte_count_high <= host_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_fault_reg <= 1'b0;
      ready_low <= 1'b0;
      cmd_prev_reg <= 1'b0;
      ale_prev_reg <= 1'b0;
    end else if (clk_en) begin
      // Set wins over a clearing write in the same cycle
      bus_fault_reg <= fault_set || (bus_fault_reg && !fault_clr);
      ready_low <= ready_next;
      cmd_prev_reg <= cmd_strobe;
      ale_prev_reg <= addr_latch_en;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_sel <= BOOT_SEL_RESET;
      pnp_reg <= 1'b0;
      link_reg <= 1'b0;
      active_media <= MEDIA_TWISTED;
      coax_enable_out <= 1'b0;
      host_rsp <= '0;
    end else if (clk_en) begin
      if (cfg_load) begin
        boot_sel <= load_boot_sel;
      end else if (boot_wr) begin
        boot_sel <= host_req.wdata[BOOT_SEL_LSB +: 4];
      end
      pnp_reg <= plug_play_state;
      link_reg <= link_good_flag;
      active_media <= media_next;
      coax_enable_out <= (media_next == MEDIA_COAX);
      host_rsp.valid <= host_req.rd;
      host_rsp.data <= host_req.rd ? rdata_next : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Boot ROM window
  // ----------------------------------------------------------------
  rom_window_decode u_rom (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .boot_sel(boot_sel),
    .rom_enable(rom_enable),
    .rom_base(rom_base),
    .rom_size(rom_size)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unpaired_write;
    @(posedge clk) disable iff (!reset_n)
    clk_en && host_req.wr && hit_media && !unlock_reg
      |=> remote_byte_count_high == $past(host_req.wdata);
  endproperty
  a_unpaired_write: assert property (p_unpaired_write)
    else $error("Unpaired write missed the byte count");

  property p_paired_write;
    @(posedge clk) disable iff (!reset_n)
    clk_en && host_req.rd && hit_media ##1 clk_en && host_req.wr && hit_media
      |=> media_sel_reg == $past(host_req.wdata[1:0]);
  endproperty
  a_paired_write: assert property (p_paired_write)
    else $error("Paired write did not reach the media register");

  property p_coax;
    @(posedge clk) disable iff (!reset_n)
    clk_en && media_sel_reg == 2'h1 |=> coax_enable_out;
  endproperty
  a_coax: assert property (p_coax)
    else $error("Coax enable low with coax selected");

  property p_auto;
    @(posedge clk) disable iff (!reset_n)
    clk_en && media_sel_reg == 2'h3 && link_reg |=> active_media == MEDIA_TWISTED;
  endproperty
  a_auto: assert property (p_auto)
    else $error("Auto detect ignored a good link");

  property p_link_read;
    @(posedge clk) disable iff (!reset_n)
    clk_en && host_req.rd && hit_media |=> host_rsp.data[LINK_GOOD_BIT] == $past(link_reg);
  endproperty
  a_link_read: assert property (p_link_read)
    else $error("Link bit reads wrong");

  property p_ready_cmd;
    @(posedge clk) disable iff (!reset_n)
    clk_en && !ready_timing_reg && wait_needed && cmd_rise && !ready_low |=> ready_low;
  endproperty
  a_ready_cmd: assert property (p_ready_cmd)
    else $error("Ready not pulled low after command strobe");

  property p_ready_ale;
    @(posedge clk) disable iff (!reset_n)
    clk_en && ready_timing_reg && wait_needed && ale_rise && !ready_low |=> ready_low;
  endproperty
  a_ready_ale: assert property (p_ready_ale)
    else $error("Ready not pulled low after latch enable");

  property p_fault;
    @(posedge clk) disable iff (!reset_n)
    clk_en && ready_low && cmd_fall && wait_needed |=> bus_fault_reg;
  endproperty
  a_fault: assert property (p_fault)
    else $error("Bus fault not flagged");

  property p_load;
    @(posedge clk) disable iff (!reset_n)
    clk_en && cfg_load |=> boot_sel == $past(load_boot_sel);
  endproperty
  a_load: assert property (p_load)
    else $error("Boot select not loaded");

  property p_boot_read;
    @(posedge clk) disable iff (!reset_n)
    clk_en && host_req.rd && hit_boot
      |=> host_rsp.data == {1'b0, $past(pnp_reg), 2'b00, $past(boot_sel)};
  endproperty
  a_boot_read: assert property (p_boot_read)
    else $error("Boot register read wrong");

endmodule : media_boot_cfg
`default_nettype wire

//--- tb/isa_host_model.sv
`default_nettype none
module isa_host_model
  import cfg_regs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Host side of the slot
  output host_req_t host_req,
  output logic cmd_strobe,
  output logic addr_latch_en
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    host_req = '0;
    cmd_strobe = 1'b0;
    addr_latch_en = 1'b0;
  end

  // ------------
  // Bus cycles
  // ------------
  // Called back to back for a read followed directly by a write
  task automatic access(input logic rd, input logic [1:0] page, input logic [3:0] addr,
                        input logic [7:0] d);
    @(posedge clk);
    host_req <= '{rd: rd, wr: !rd, page: page, addr: addr, wdata: d};
  endtask : access

  // Released address and data lines do not keep the last value; the page is kept
  task automatic idle();
    @(posedge clk);
    host_req.rd <= 1'b0;
    host_req.wr <= 1'b0;
    host_req.addr <= ~host_req.addr;
    host_req.wdata <= ~host_req.wdata;
  endtask : idle

  task automatic strobes(input logic cmd, input logic ale);
    @(posedge clk);
    cmd_strobe <= cmd;
    addr_latch_en <= ale;
  endtask : strobes
endmodule : isa_host_model
`default_nettype wire

//--- tb/media_boot_cfg_test.sv
`default_nettype none
module media_boot_cfg_test import cfg_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, reset_n, cmd_strobe, addr_latch_en, wait_needed, link_good_flag, coax_detect;
  logic cfg_load, plug_play_state, coax_enable_out, ready_low, rom_enable, clk_en;
  logic [3:0] load_boot_sel, boot_sel;
  logic [5:0] rom_base;
  logic [7:0] remote_byte_count_high;
  host_req_t host_req;
  host_rsp_t host_rsp;
  media_t active_media;
  rom_size_t rom_size;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  isa_host_model host (.clk, .host_req, .cmd_strobe, .addr_latch_en);
  media_boot_cfg u_dut (.clk, .reset_n, .clk_en, .host_req, .host_rsp,
    .remote_byte_count_high, .cmd_strobe, .addr_latch_en, .wait_needed, .ready_low,
    .link_good_flag, .coax_detect, .coax_enable_out, .active_media, .cfg_load,
    .load_boot_sel, .plug_play_state, .boot_sel, .rom_enable, .rom_base, .rom_size);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  // ---------
  // Helpers
  // ---------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rd(input logic [1:0] pg, input logic [3:0] a, input logic [7:0] exp,
                    input string w);
    host.access(1'b1, pg, a, 8'h00);
    host.idle();
    #1 check(16'({host_rsp.valid, host_rsp.data}), {8'h01, exp}, w);
  endtask : rd

  task automatic wr(input logic [1:0] pg, input logic [3:0] a, input logic [7:0] d);
    host.access(1'b0, pg, a, d);
    host.idle();
    #1;
  endtask : wr

  task automatic pair(input logic [7:0] d, input logic [7:0] exp_rd);
    host.access(1'b1, PAGE_MEDIA, OFFSET_CFG, 8'h00);
    host.access(1'b0, PAGE_MEDIA, OFFSET_CFG, d);
    #1 check(16'(host_rsp.data), 16'(exp_rd), "pair read");
    host.idle();
    repeat (2) @(posedge clk);
    #1;
  endtask : pair

  function automatic logic [8:0] rom_exp(input int c);
    if (c < 2) return 9'h000;
    if (c < 10) return {1'b1, ROM_16K, 6'(8'h30 + c - 2)};
    if (c < 14) return {1'b1, ROM_32K, 6'(8'h30 + 2 * (c - 10))};
    return {1'b1, ROM_64K, (c == 14) ? 6'h30 : 6'h34};
  endfunction : rom_exp

  // -----------
  // Scenarios
  // -----------
  task automatic t_regs();
    rd(PAGE_MEDIA, OFFSET_CFG, 8'h04, "reset media");
    rd(PAGE_MEDIA, 4'h3, 8'h00, "unmapped");
    pair(8'h01, 8'h04);
    wr(PAGE_MEDIA, OFFSET_CFG, 8'h5a);
    check(16'(remote_byte_count_high), 16'h005a, "unpaired");
    rd(PAGE_MEDIA, OFFSET_CFG, 8'h05, "media kept");
    rd(PAGE_MEDIA, 4'h3, 8'h00, "other read");
    wr(PAGE_MEDIA, OFFSET_CFG, 8'h22);
    check(16'(remote_byte_count_high), 16'h0022, "lock cleared");
    @(posedge clk) link_good_flag <= 1'b0;
    rd(PAGE_MEDIA, OFFSET_CFG, 8'h01, "link fail");
    @(posedge clk) link_good_flag <= 1'b1;
    $display("t_regs done");
  endtask : t_regs

  // Frozen clock enable must swallow a write that would land otherwise
  task automatic t_freeze();
    @(posedge clk) clk_en <= 1'b0;
    wr(PAGE_MEDIA, OFFSET_CFG, 8'h99);
    @(posedge clk) clk_en <= 1'b1;
    check(16'(remote_byte_count_high), 16'h0022, "frozen count");
    rd(PAGE_MEDIA, OFFSET_CFG, 8'h05, "frozen media");
    $display("t_freeze done");
  endtask : t_freeze

  task automatic t_media();
    media_t exp;
    for (int c = 0; c < 4; c++) begin
      pair(8'(c), (c == 0) ? 8'h05 : 8'(c + 3));
      exp = (c == 3) ? MEDIA_TWISTED : media_t'(c);
      check(16'(active_media), 16'(exp), "media");
      check(16'(coax_enable_out), 16'(c == 1), "coax enable");
    end
    @(posedge clk) link_good_flag <= 1'b0;
    @(posedge clk) coax_detect <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(16'(active_media), 16'(MEDIA_COAX), "auto coax");
    check(16'(coax_enable_out), 16'h0001, "auto coax enable");
    @(posedge clk) coax_detect <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(16'(active_media), 16'(MEDIA_AUI), "auto aui");
    @(posedge clk) link_good_flag <= 1'b1;
    $display("t_media done");
  endtask : t_media

  task automatic t_ready();
    pair(8'h00, 8'h07);
    @(posedge clk) wait_needed <= 1'b1;
    host.strobes(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    #1 check(16'(ready_low), 16'h0000, "latch ignored");
    host.strobes(1'b0, 1'b0);
    host.strobes(1'b1, 1'b0);
    @(posedge clk);
    #1 check(16'(ready_low), 16'h0001, "strobe wait");
    host.strobes(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    #1 check(16'(ready_low), 16'h0000, "released");
    rd(PAGE_MEDIA, OFFSET_CFG, 8'h24, "fault set");
    pair(8'h10, 8'h24);
    host.strobes(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    #1 check(16'(ready_low), 16'h0000, "strobe ignored");
    host.strobes(1'b0, 1'b1);
    @(posedge clk);
    #1 check(16'(ready_low), 16'h0001, "latch wait");
    @(posedge clk) wait_needed <= 1'b0;
    host.strobes(1'b0, 1'b0);
    rd(PAGE_MEDIA, OFFSET_CFG, 8'h14, "fault clear");
    $display("t_ready done");
  endtask : t_ready

  task automatic t_boot();
    @(posedge clk) begin
      cfg_load <= 1'b1;
      load_boot_sel <= 4'h3;
      plug_play_state <= 1'b1;
    end
    wr(PAGE_BOOT, OFFSET_CFG, 8'h0c);
    @(posedge clk) cfg_load <= 1'b0;
    rd(PAGE_BOOT, OFFSET_CFG, 8'h43, "loaded");
    for (int c = 0; c < 16; c++) begin
      wr(PAGE_BOOT, OFFSET_CFG, 8'hf0 | 8'(c));
      rd(PAGE_BOOT, OFFSET_CFG, 8'h40 | 8'(c), "boot select");
      check(16'({rom_enable, rom_size, rom_base}), 16'(rom_exp(c)), "window");
    end
    @(posedge clk) plug_play_state <= 1'b0;
    rd(PAGE_BOOT, OFFSET_CFG, 8'h0f, "pnp off");
    $display("t_boot done");
  endtask : t_boot

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    wait_needed = 1'b0;
    link_good_flag = 1'b1;
    coax_detect = 1'b0;
    cfg_load = 1'b0;
    load_boot_sel = 4'h0;
    plug_play_state = 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    #1 check(16'({boot_sel, coax_enable_out, rom_enable}), 16'h0000, "reset outputs");
    t_regs();
    t_freeze();
    t_media();
    t_ready();
    t_boot();
    finish_test();
  end
endmodule : media_boot_cfg_test
`default_nettype wire
